/* inc/usart_map.vh */
`ifndef USART_MAP_VH
`define USART_MAP_VH
// Register byte offsets
`define OFS_STATUS_A  8'h00
`define OFS_CONTROL_B 8'h04
`define OFS_CONTROL_C 8'h08
`define OFS_BAUD      8'h0c
`define OFS_DATA      8'h10
// Status A fields
`define SA_RXC   7
`define SA_TXC   6
`define SA_UDRE  5
`define SA_U2X   1
// Control B fields
`define CB_TXCIE 6
`define CB_UDRIE 5
`define CB_RX_ON     4
`define CB_TX_ON     3
`define CB_SZ2       2
`define CB_RX_NINTH  1
`define CB_TX_NINTH  0
// Control C fields
`define CC_MASTER 7
`define CC_SYNC   6
`define CC_PAR    5
`define CC_ODD    4
`define CC_STOP2  3
`define CC_SZ_HI  2
`define CC_SZ_LO  1
`define CC_POL    0
// Reset values
`define RST_CTRL_B 8'h00
`define RST_CTRL_C 8'h06
`define RST_BAUD   12'h000
// Oversampling ratios and start check points
`define OS_NORMAL  4'hf
`define OS_DOUBLE  4'h7
`define HALF_NORM  4'h7
`define HALF_DBL   4'h3
// Nine-bit character size code
`define SZ_NINE    3'h7
`endif

/* sim/serial_peer.sv */
`timescale 1ns/1ps
// ****************
// Remote peer: catches and sends frames
// ****************
module serial_peer (
	// Clock
	input  wire        pclk,
	// Lines
	input  wire        tx_line,
	output logic       rx_line,
	// Format
	input  wire [15:0] bit_clks,
	input  wire [3:0]  nbits
);
	logic [9:0] got_q[$];  // Caught frames
	int         gap_q[$];  // Cycles between starts
	int         n_got;     // Frame count
	int         t_now;     // Cycle stamp
	int         t_last;    // Last start stamp
	logic [9:0] bits;      // Frame in progress
	// Cycle stamp
	initial begin
		t_now = 0;
		forever @(posedge pclk) t_now++;
	end
	// Catch frames at mid bit
	initial begin
		rx_line = 1'b1;
		n_got = 0;
		t_last = 0;
		forever begin
			@(negedge tx_line);
			gap_q.push_back(t_now - t_last);
			t_last = t_now;
			bits = 10'h000;
			repeat (bit_clks / 2) @(posedge pclk);
			for (int i = 0; i < nbits; i++) begin
				repeat (bit_clks) @(posedge pclk);
				bits[i] = tx_line;
			end
			repeat (bit_clks) @(posedge pclk);
			got_q.push_back(bits);
			n_got++;
		end
	end
	// Send start, n bits, two stops
	task automatic send(input logic [9:0] d, input int n);
		rx_line <= 1'b0;
		repeat (bit_clks) @(posedge pclk);
		for (int k = 0; k < n; k++) begin
			rx_line <= d[k];
			repeat (bit_clks) @(posedge pclk);
		end
		rx_line <= 1'b1;
		repeat (2 * bit_clks) @(posedge pclk);
	endtask
endmodule

/* sim/tb.sv */
`timescale 1ns/1ps
`include "usart_map.vh"
// ****************
// Bench
// ****************
module tb;
	logic        pclk, presetn, psel, penable, pwrite, global_irq_en, tx_complete_irq_ack, err;
	logic [7:0]  paddr, lfsr, d0, d1;
	logic [31:0] pwdata, prdata, rdv;
	logic        pready, pslverr, tx_empty_irq, tx_complete_irq, serial_out_pin, serial_out_oe_n;
	logic        serial_in_pin, serial_in_claimed, pen, odd, st2, u2x;
	logic        xck_in, xck_out, xck_oe_n, xck_run;
	logic [15:0] bit_clks;
	logic [3:0]  nbits;
	logic [2:0]  sz;
	logic [9:0]  ex;
	int          miscompares, n_checks, k, nb;
	usart_tx_rx_datapath u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .global_irq_en, .tx_complete_irq_ack, .tx_empty_irq, .tx_complete_irq,
		.serial_out_pin, .serial_out_oe_n, .serial_in_pin, .serial_in_claimed, .serial_clock_in(xck_in),
		.serial_clock_out(xck_out), .serial_clock_oe_n(xck_oe_n));
	serial_peer u_peer (.pclk, .tx_line(serial_out_pin), .rx_line(serial_in_pin), .bit_clks, .nbits);
	// Clock
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// Slave clock on the clock pin, still unless a slave test runs
	initial begin
		xck_in = 1'b0;
		forever begin
			repeat (4) @(posedge pclk);
			xck_in <= xck_run & ~xck_in;
		end
	end
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// Masked data with parity above it
	function automatic logic [9:0] frame(input logic [8:0] d, input int n, input logic p, input logic o);
		logic [8:0] m;
		m = d & ((9'h001 << n) - 9'h001);
		return p ? ({1'b0, m} | ({9'h000, ^m ^ o} << n)) : {1'b0, m};
	endfunction
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One APB transfer, waits for pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task poll(input logic [7:0] a, input int b);
		for (int i = 0; i < 300; i++) begin
			apb(1'b0, a, 32'h0);
			if (rdv[b] === 1'b1) break;
		end
	endtask
	task wpeer(input int n);
		for (int i = 0; i < 4000 && u_peer.n_got < n; i++) @(posedge pclk);
	endtask
	task test_done;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (60000) @(posedge pclk);
		miscompares++;
		test_done;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, global_irq_en, tx_complete_irq_ack, xck_run} = '0;
		{miscompares, n_checks} = '0;
		{bit_clks, nbits, lfsr} = {16'd32, 4'd8, 8'h28};
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `OFS_CONTROL_C, 32'h0);
		chk("ctrl_c", rdv, 32'h6);
		apb(1'b0, 8'h14, 32'h0);
		chk("slverr", {31'h0, err}, 32'h1);
		// Size codes 0 to 3 and 7, parity modes, stops, double speed
		for (k = 0; k < 5; k++) begin
			{sz, nb, pen, odd, st2, u2x} = {(k == 4) ? 3'h7 : k[2:0], (k == 4) ? 32'd9 : k + 32'd5, k != 1, k[1], k[0], k == 2};
			bit_clks = u2x ? 16'd16 : 16'd32;
			nbits = nb + pen;
			lfsr = lfsr_next(lfsr);
			d0 = lfsr;
			lfsr = lfsr_next(lfsr);
			d1 = (k == 0) ? 8'hff : lfsr;
			apb(1'b1, `OFS_BAUD, 32'h1);
			apb(1'b1, `OFS_STATUS_A, {30'h0, u2x, 1'b0});
			apb(1'b1, `OFS_CONTROL_C, {26'h0, pen, odd, st2, sz[1:0], 1'b0});
			apb(1'b1, `OFS_CONTROL_B, {27'h3, sz[2], 1'b0, d1[0]});
			u_peer.gap_q.delete();
			u_peer.got_q.delete();
			apb(1'b1, `OFS_DATA, {24'h0, d0});
			poll(`OFS_STATUS_A, `SA_UDRE);
			apb(1'b1, `OFS_CONTROL_B, {27'h3, sz[2], 1'b0, d0[0]});
			apb(1'b1, `OFS_DATA, {24'h0, d1});
			wpeer(u_peer.n_got + 2);
			chk("frame0", u_peer.got_q[0], frame({d1[0], d0}, nb, pen, odd));
			chk("frame1", u_peer.got_q[1], frame({d0[0], d1}, nb, pen, odd));
			chk("gap", u_peer.gap_q[1], (2 + nb + pen + st2) * bit_clks);
			poll(`OFS_STATUS_A, `SA_TXC);
			chk("flags", rdv[6:5], 2'h3);
			apb(1'b1, `OFS_STATUS_A, {25'h0, 1'b1, 4'h0, u2x, 1'b0});
			apb(1'b0, `OFS_STATUS_A, 32'h0);
			chk("txc_w1c", rdv[6], 1'b0);
			chk("claimed", serial_in_claimed, 1'b1);
			ex = frame({d1[1], ~d1}, nb, pen, odd);
			u_peer.send(ex, nb + pen);
			poll(`OFS_STATUS_A, `SA_RXC);
			apb(1'b0, `OFS_DATA, 32'h0);
			ex = frame({d1[1], ~d1}, nb, 1'b0, 1'b0);
			chk("rx_data", {24'h0, rdv[7:0]}, {24'h0, ex[7:0]});
			$display("test format %0d done", k);
		end
		// Interrupt gating and acknowledge
		{bit_clks, nbits} = {16'd32, 4'd8};
		apb(1'b1, `OFS_CONTROL_C, 32'h6);
		apb(1'b1, `OFS_STATUS_A, 32'h0);
		apb(1'b1, `OFS_CONTROL_B, 32'h78);
		global_irq_en <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("empty_irq", tx_empty_irq, 1'b1);
		global_irq_en <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("empty_irq_off", tx_empty_irq, 1'b0);
		global_irq_en <= 1'b1;
		apb(1'b1, `OFS_DATA, 32'h5a);
		for (k = 0; k < 2000 && tx_complete_irq !== 1'b1; k++) @(posedge pclk);
		chk("cmpl_irq", tx_complete_irq, 1'b1);
		tx_complete_irq_ack <= 1'b1;
		@(posedge pclk);
		tx_complete_irq_ack <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("cmpl_ack", tx_complete_irq, 1'b0);
		$display("test irq done");
		// Disable while a byte is pending
		u_peer.got_q.delete();
		apb(1'b1, `OFS_DATA, 32'ha5);
		apb(1'b1, `OFS_CONTROL_B, 32'h0);
		chk("oe_hold", serial_out_oe_n, 1'b0);
		poll(`OFS_STATUS_A, `SA_TXC);
		repeat (4) @(posedge pclk);
		chk("oe_free", serial_out_oe_n, 1'b1);
		chk("last_frame", u_peer.got_q[0], 10'h0a5);
		chk("rx_free", serial_in_claimed, 1'b0);
		$display("test disable done");
		// Sync master with polarity zero, then slave with polarity one
		for (k = 0; k < 2; k++) begin
			bit_clks = (k == 0) ? 16'd4 : 16'd8;
			nbits = 4'd8;
			xck_run <= (k == 1);
			lfsr = lfsr_next(lfsr);
			d0 = lfsr;
			apb(1'b1, `OFS_CONTROL_C, (k == 0) ? 32'hc6 : 32'h47);
			apb(1'b1, `OFS_CONTROL_B, 32'h18);
			u_peer.got_q.delete();
			apb(1'b1, `OFS_DATA, {24'h0, d0});
			nb = 0;
			for (int i = 0; i < 8; i++) begin
				@(posedge pclk);
				nb += xck_out;
			end
			chk("xck_oe", {31'h0, xck_oe_n}, {31'h0, k[0]});
			if (k == 0) chk("xck_duty", nb, 32'd4);
			wpeer(u_peer.n_got + 1);
			chk("sync_tx", u_peer.got_q[0], {22'h0, d0});
			u_peer.send({2'h0, ~d0}, 8);
			poll(`OFS_STATUS_A, `SA_RXC);
			apb(1'b0, `OFS_DATA, 32'h0);
			chk("sync_rx", {24'h0, rdv[7:0]}, {24'h0, ~d0});
			$display("test sync %0d done", k);
		end
		xck_run <= 1'b0;
		test_done;
	end
endmodule

/* sim/usart_checker_asserts.sv */
`timescale 1ns/1ps
`include "usart_map.vh"
// ****************
// Port checker
// ****************
module usart_checker (
	// APB
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire        pready,
	input wire        pslverr,
	// Interrupts
	input wire        global_irq_en,
	input wire        tx_complete_irq_ack,
	input wire        tx_empty_irq,
	input wire        tx_complete_irq,
	// Pins
	input wire        serial_out_pin,
	input wire        serial_out_oe_n,
	input wire        serial_in_claimed
);
	logic [11:0] baud_reg;  // Divider copy
	logic        u2x_reg;   // Double speed copy
	logic        sync_reg;  // Sync mode copy
	logic        tx_on_reg; // Tx enable copy
	logic        rx_on_reg; // Rx enable copy
	int          lo_cnt;    // Cycles line low
	wire         wr_c = psel & penable & pready & pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Shadow of written controls, low run count
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_reg <= 12'h000;
			u2x_reg <= 1'b0;
			sync_reg <= 1'b0;
			tx_on_reg <= 1'b0;
			rx_on_reg <= 1'b0;
			lo_cnt <= 0;
		end else begin
			lo_cnt <= serial_out_pin ? 0 : lo_cnt + 1;
			if (wr_c && paddr == `OFS_BAUD) baud_reg <= pwdata[11:0];
			if (wr_c && paddr == `OFS_STATUS_A) u2x_reg <= pwdata[`SA_U2X];
			if (wr_c && paddr == `OFS_CONTROL_C) sync_reg <= pwdata[`CC_SYNC];
			if (wr_c && paddr == `OFS_CONTROL_B) begin
				tx_on_reg <= pwdata[`CB_TX_ON];
				rx_on_reg <= pwdata[`CB_RX_ON];
			end
		end
	end
	sequence s_setup; psel && !penable; endsequence
	sequence s_answer; !pready ##1 pready; endsequence
	a_one_wait: assert property (s_setup |=> s_answer) else $error("no answer after one wait");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
	a_err_ready: assert property (pslverr |-> pready && penable) else $error("stray pslverr");
	// Divider timing holds for asynchronous frames only
	a_low_width: assert property ($rose(serial_out_pin) && !serial_out_oe_n && !sync_reg |->
		lo_cnt % ((u2x_reg ? 8 : 16) * (baud_reg + 1)) == 0) else $error("bit width off");
	a_rel_high: assert property ($rose(serial_out_oe_n) |-> $past(serial_out_pin, 2))
		else $error("pin released mid frame");
	a_tx_owns: assert property (tx_on_reg && $past(tx_on_reg, 3) |-> !serial_out_oe_n)
		else $error("tx pin not owned");
	a_rx_owns: assert property (rx_on_reg && $past(rx_on_reg, 2) |-> serial_in_claimed)
		else $error("rx pin not owned");
	a_empty_gate: assert property (tx_empty_irq |-> $past(global_irq_en)) else $error("empty irq ungated");
	a_ack_clear: assert property (tx_complete_irq_ack && tx_complete_irq |-> ##[1:2] !tx_complete_irq)
		else $error("complete irq kept");
endmodule
bind usart_tx_rx_datapath usart_checker u_chk (.*);

/* verilog/usart_tx_rx_datapath.v */
`timescale 1ns/1ps
// Contract
// - Transmit enable claims the serial output pin
// - Sync transmit drives or uses clock pin
// - Data register write loads buffer, starts sending
// - Buffer moves to shifter when idle/frame ends
// - Shifter sends one frame at selected rate
// - Unused upper transmit data bits are ignored
// - Buffer-empty flag shows transmit buffer empty
// - Data register write clears buffer-empty flag
// - Buffer-empty request held while flag set
// - Complete flag set when frame done, empty
// - Complete flag clears on ack or one
// - Complete request raised while flag set
// - Parity inserted after data when enabled
// - Disable waits until shifter and buffer empty (data pin only; sync master clock pin is freed at once unless receive is on)
// - Receive enable claims the serial input pin
// - Sync receive uses clock pin as transfer
// - Receive starts on valid start bit only
// - Second stop bit ignored by receiver
// - First stop moves frame to receive buffer
// - Unused received upper bits read as zero
// - Start, data LSB first, idle high
// - Parity is xor of data, odd inverts
// - Async rate is clock over 16/8 times (divider + 1)
// - Clock polarity picks change and sample edges
`include "usart_map.vh"
module usart_tx_rx_datapath (
	// APB
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// CPU interrupt side
	input  wire        global_irq_en,
	input  wire        tx_complete_irq_ack,
	output reg         tx_empty_irq,
	output reg         tx_complete_irq,
	// Serial pins
	output reg         serial_out_pin,
	output reg         serial_out_oe_n,
	input  wire        serial_in_pin,
	output reg         serial_in_claimed,
	input  wire        serial_clock_in,
	output reg         serial_clock_out,
	output reg         serial_clock_oe_n
);
	// ****************************************
	// Registers and state
	// ****************************************
	reg  [7:0]  ctrl_b_reg;          // Control B
	reg  [7:0]  ctrl_c_reg;          // Control C
	reg  [11:0] baud_reg;            // Baud divider
	reg         u2x_reg;             // Double speed
	reg         txc_reg;             // Transmit complete flag
	reg         rxc_reg;             // Receive complete flag
	reg  [8:0]  tx_buf_reg;          // Transmit buffer
	reg         tx_full_reg;         // Buffer holds data
	reg  [12:0] tx_shift_reg;        // Frame being sent
	reg  [3:0]  tx_left_reg;         // Bits left incl. current
	reg         tx_busy_reg;         // Frame in progress
	reg  [3:0]  tx_os_reg;           // Oversample phase
	reg  [11:0] presc_reg;           // Prescaler
	reg  [8:0]  rx_buf_reg;          // Receive buffer
	reg  [8:0]  rx_data_reg;         // Receive shifter
	reg  [3:0]  rx_idx_reg;          // Bit index in frame
	reg         rx_busy_reg;         // Reception running
	reg  [3:0]  rx_os_reg;           // Oversample phase
	reg         rxd_s1_reg;          // Input synchroniser
	reg         rxd_s2_reg;
	reg         xck_s1_reg;          // Clock synchroniser
	reg         xck_s2_reg;
	reg         xck_s3_reg;          // Edge history
	reg         xck_reg;             // Master clock level

	// ****************************************
	// Decoded fields
	// ****************************************
	wire        tx_en    = ctrl_b_reg[`CB_TX_ON];
	wire        rx_en    = ctrl_b_reg[`CB_RX_ON];
	wire        sync     = ctrl_c_reg[`CC_SYNC];
	wire        master   = ctrl_c_reg[`CC_MASTER];
	wire        par_en   = ctrl_c_reg[`CC_PAR];
	wire [2:0]  size     = {ctrl_b_reg[`CB_SZ2], ctrl_c_reg[`CC_SZ_HI:`CC_SZ_LO]};
	wire [3:0]  nbits    = (size == `SZ_NINE) ? 4'h9 : {2'b00, size[1:0]} + 4'h5;
	wire [3:0]  os_top   = u2x_reg ? `OS_DOUBLE : `OS_NORMAL;
	wire [3:0]  os_half  = u2x_reg ? `HALF_DBL : `HALF_NORM;
	wire        presc_tick = (presc_reg == baud_reg);

	// Data mask for the character size
	wire [8:0]  size_mask = (9'h1ff >> (4'h9 - nbits));

	// ****************************************
	// Clock pin edges
	// ****************************************
	// Master edges come from own divider, slave edges from the pin
	wire rise_m = presc_tick & ~xck_reg;
	wire fall_m = presc_tick & xck_reg;
	wire rise_s = xck_s2_reg & ~xck_s3_reg;
	wire fall_s = ~xck_s2_reg & xck_s3_reg;
	wire rise   = master ? rise_m : rise_s;
	wire fall   = master ? fall_m : fall_s;
	// Polarity zero: change on rising, sample on falling
	wire chg_edge  = ctrl_c_reg[`CC_POL] ? fall : rise;
	wire samp_edge = ctrl_c_reg[`CC_POL] ? rise : fall;

	// Bit tick for the transmitter
	wire tx_tick = sync ? chg_edge : (presc_tick & (tx_os_reg == os_top));

	// ****************************************
	// Frame builder
	// ****************************************
	function [12:0] build_frame;
		input [8:0] d;
		input [3:0] n;
		input       pen;
		input       odd;
		integer     i;
		reg         p;
		begin
			build_frame = 13'h1fff;
			build_frame[0] = 1'b0;
			p = odd;
			for (i = 0; i < 9; i = i + 1) begin
				if (i < n) begin
					build_frame[i + 1] = d[i];
					p = p ^ d[i];
				end
			end
			if (pen) begin
				build_frame[n + 1] = p;
			end
		end
	endfunction

	wire [12:0] next_frame = build_frame(tx_buf_reg, nbits, par_en, ctrl_c_reg[`CC_ODD]);
	wire [3:0]  frame_len  = 4'h2 + nbits + {3'h0, par_en} + {3'h0, ctrl_c_reg[`CC_STOP2]};

	// ****************************************
	// APB decode
	// ****************************************
	wire commit  = psel & penable & pready;
	wire wr      = commit & pwrite;
	wire rd      = commit & ~pwrite;
	wire hit_a   = (paddr == `OFS_STATUS_A);
	wire hit_b   = (paddr == `OFS_CONTROL_B);
	wire hit_c   = (paddr == `OFS_CONTROL_C);
	wire hit_bd  = (paddr == `OFS_BAUD);
	wire hit_d   = (paddr == `OFS_DATA);
	wire mapped  = hit_a | hit_b | hit_c | hit_bd | hit_d;
	wire data_wr = wr & hit_d;
	wire data_rd = rd & hit_d;

	// Transmit events
	wire tx_done  = tx_tick & tx_busy_reg & (tx_left_reg == 4'h1);
	wire tx_load  = tx_tick & tx_full_reg & (~tx_busy_reg | tx_done);
	wire txc_set  = tx_done & ~tx_full_reg;
	wire txc_clr  = tx_complete_irq_ack | (wr & hit_a & pwdata[`SA_TXC]);

	// Receive events
	wire rx_take;
	wire rx_start;
	wire rx_last  = rx_take & (rx_idx_reg == nbits + {3'h0, par_en});

	// Async start check at bit middle, sync start at sample edge
	assign rx_start = rx_en & ~rx_busy_reg & ~rxd_s2_reg &
		(sync ? samp_edge : (presc_tick & (rx_os_reg == os_half)));
	assign rx_take  = rx_busy_reg &
		(sync ? samp_edge : (presc_tick & (rx_os_reg == os_top)));

	// Read mux
	reg [31:0] rdata;
	always @* begin
		rdata = 32'h0000_0000;
		if (hit_a) begin
			rdata[`SA_RXC]  = rxc_reg;
			rdata[`SA_TXC]  = txc_reg;
			rdata[`SA_UDRE] = ~tx_full_reg;
			rdata[`SA_U2X]  = u2x_reg;
		end else if (hit_b) begin
			rdata[7:0] = {ctrl_b_reg[7:2], rx_buf_reg[8], ctrl_b_reg[0]};
		end else if (hit_c) begin
			rdata[7:0] = ctrl_c_reg;
		end else if (hit_bd) begin
			rdata[11:0] = baud_reg;
		end else if (hit_d) begin
			rdata[7:0] = rx_buf_reg[7:0] & size_mask[7:0];
		end
	end

	// ****************************************
	// Bus slave and registers
	// ****************************************
	// One wait state: ready rises the cycle after the access phase opens
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			prdata     <= 32'h0000_0000;
			ctrl_b_reg <= `RST_CTRL_B;
			ctrl_c_reg <= `RST_CTRL_C;
			baud_reg   <= `RST_BAUD;
			u2x_reg    <= 1'b0;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			if (psel & penable & ~pready) begin
				prdata <= rdata;
			end
			// Register writes
			if (wr) begin
				if (hit_a) begin
					u2x_reg <= pwdata[`SA_U2X];
				end else if (hit_b) begin
					ctrl_b_reg <= {pwdata[7:2], 1'b0, pwdata[0]};
				end else if (hit_c) begin
					ctrl_c_reg <= pwdata[7:0];
				end else if (hit_bd) begin
					baud_reg <= pwdata[11:0];
				end
			end
		end
	end

	// ****************************************
	// Prescaler and master clock
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_reg <= 12'h000;
			xck_reg   <= 1'b0;
		end else begin
			// Divider counts 0..baud, one tick per wrap
			if (presc_tick) begin
				presc_reg <= 12'h000;
			end else begin
				presc_reg <= presc_reg + 12'h001;
			end
			// Master clock toggles each tick: rate is clock over 2(baud+1)
			if (sync & master & presc_tick) begin
				xck_reg <= ~xck_reg;
			end else if (!sync) begin
				xck_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// Transmitter
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_buf_reg   <= 9'h000;
			tx_full_reg  <= 1'b0;
			tx_shift_reg <= 13'h1fff;
			tx_left_reg  <= 4'h0;
			tx_busy_reg  <= 1'b0;
			tx_os_reg    <= 4'h0;
			txc_reg      <= 1'b0;
		end else begin
			// Oversample phase for async bit timing
			if (presc_tick) begin
				tx_os_reg <= (tx_os_reg == os_top) ? 4'h0 : tx_os_reg + 4'h1;
			end
			// Buffer: write fills it, move to shifter empties it
			if (data_wr) begin
				tx_buf_reg  <= {ctrl_b_reg[`CB_TX_NINTH], pwdata[7:0]} & size_mask;
				tx_full_reg <= 1'b1;
			end else if (tx_load) begin
				tx_full_reg <= 1'b0;
			end
			// Shifter
			if (tx_load) begin
				tx_shift_reg <= next_frame;
				tx_left_reg  <= frame_len;
				tx_busy_reg  <= 1'b1;
			end else if (tx_done) begin
				tx_busy_reg  <= 1'b0;
				tx_shift_reg <= 13'h1fff;
			end else if (tx_tick & tx_busy_reg) begin
				tx_shift_reg <= {1'b1, tx_shift_reg[12:1]};
				tx_left_reg  <= tx_left_reg - 4'h1;
			end
			// Complete flag: set wins over clear
			txc_reg <= txc_set | (txc_reg & ~txc_clr);
		end
	end

	// ****************************************
	// Receiver
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_buf_reg  <= 9'h000;
			rx_data_reg <= 9'h000;
			rx_idx_reg  <= 4'h0;
			rx_busy_reg <= 1'b0;
			rx_os_reg   <= 4'h0;
			rxc_reg     <= 1'b0;
		end else begin
			if (!rx_en) begin
				// Disable is immediate and clears the complete flag; the buffer keeps its data
				rx_busy_reg <= 1'b0;
				rx_os_reg   <= 4'h0;
				rxc_reg     <= 1'b0;
			end else begin
				// Oversample counter: restarts on line noise while idle
				if (!rx_busy_reg & rxd_s2_reg) begin
					rx_os_reg <= 4'h0;
				end else if (rx_start) begin
					rx_os_reg <= 4'h0;
				end else if (presc_tick) begin
					rx_os_reg <= (rx_os_reg == os_top) ? 4'h0 : rx_os_reg + 4'h1;
				end
				if (rx_start) begin
					rx_busy_reg <= 1'b1;
					rx_idx_reg  <= 4'h0;
					rx_data_reg <= 9'h000;
				end else if (rx_take) begin
					if (rx_idx_reg < nbits) begin
						rx_data_reg[rx_idx_reg] <= rxd_s2_reg;
					end
					rx_idx_reg <= rx_idx_reg + 4'h1;
					if (rx_last) begin
						rx_busy_reg <= 1'b0;
						rx_buf_reg  <= rx_data_reg;
					end
				end
				// Complete flag: new frame wins over data read
				rxc_reg <= rx_last | (rxc_reg & ~data_rd);
			end
		end
	end

	// ****************************************
	// Pins and interrupt requests
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxd_s1_reg        <= 1'b1;
			rxd_s2_reg        <= 1'b1;
			xck_s1_reg        <= 1'b0;
			xck_s2_reg        <= 1'b0;
			xck_s3_reg        <= 1'b0;
			serial_out_pin    <= 1'b1;
			serial_out_oe_n   <= 1'b1;
			serial_in_claimed <= 1'b0;
			serial_clock_out  <= 1'b0;
			serial_clock_oe_n <= 1'b1;
			tx_empty_irq      <= 1'b0;
			tx_complete_irq   <= 1'b0;
		end else begin
			// Input synchronisers
			rxd_s1_reg <= serial_in_pin;
			rxd_s2_reg <= rxd_s1_reg;
			xck_s1_reg <= serial_clock_in;
			xck_s2_reg <= xck_s1_reg;
			xck_s3_reg <= xck_s2_reg;
			// Output pin held until shifter and buffer drain
			serial_out_oe_n <= ~(tx_en | tx_busy_reg | tx_full_reg);
			serial_out_pin  <= tx_shift_reg[0];
			serial_in_claimed <= rx_en;
			// Master drives the clock pin while either side is on
			serial_clock_oe_n <= ~(sync & master & (tx_en | rx_en));
			serial_clock_out  <= xck_reg;
			// Interrupt requests
			tx_empty_irq    <= ~tx_full_reg & ctrl_b_reg[`CB_UDRIE] & global_irq_en;
			tx_complete_irq <= txc_reg & ctrl_b_reg[`CB_TXCIE] & global_irq_en;
		end
	end
endmodule
